// *** hdl/gpab_pkg.sv ***
package gpab_pkg;
	// Register byte offsets on the APB word map
	localparam logic [7:0] GPAB_OFS_PORTA_LATCH = 8'h00;
	localparam logic [7:0] GPAB_OFS_PORTB_LATCH = 8'h04;
	localparam logic [7:0] GPAB_OFS_PORTA_DIR = 8'h08;
	localparam logic [7:0] GPAB_OFS_PORTB_DIR = 8'h0c;
	localparam logic [7:0] GPAB_OFS_PORTA_PULL = 8'h10;
	localparam logic [7:0] GPAB_OFS_KEYPAD_EN = 8'h14;
	localparam logic [7:0] GPAB_OFS_KEYPAD_POL = 8'h18;
	localparam logic [7:0] GPAB_OFS_ANALOG_SEL = 8'h1c;
	localparam logic [7:0] GPAB_OFS_PORTA_PIN = 8'h20;
	localparam int GPAB_PORT_W = 8;
	localparam logic [7:0] GPAB_DIR_RST = 8'h00;
	localparam logic [7:0] GPAB_PULL_RST = 8'h00;
	localparam logic [7:0] GPAB_KEY_RST = 8'h00;
	localparam logic [7:0] GPAB_ANA_RST = 8'h00;

	// Per-pin controls handed to the pad stage
	typedef struct packed {
		logic [7:0] drive_n;
		logic [7:0] data;
		logic [7:0] pull_up;
		logic [7:0] pull_down;
		logic [7:0] analog;
	} gpab_pad_ctl_t;

	// APB request as one bundle
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} gpab_apb_req_t;
endpackage

// *** hdl/gpab_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for a bus of pin levels
module gpab_sync
	import gpab_pkg::*;
#(
	parameter int W = 8
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// *** hdl/gpab_latch.sv ***
`timescale 1ns/1ps
// Data latch with no reset: contents survive a reset
module gpab_latch
	import gpab_pkg::*;
#(
	parameter int W = 8
)
(
	input wire logic clk_sys,
	input wire logic wr_en,
	input wire logic [W-1:0] wr_data,
	output logic [W-1:0] q
);
	// Deliberately unreset so software-loaded data outlives reset
	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
			q <= wr_data;
	end
endmodule

// *** hdl/gpab_port.sv ***
// Design decision made here: the APB register port.
`timescale 1ns/1ps
// Functional notes
// - Port A has eight pins, each with latch, direction and pullup bits.
// - Direction 1 drives the pin; direction 0 makes it an input.
// - Reset clears all port A direction bits.
// - Port A direction register reads back the value last written.
// - Reset leaves the port A latch unchanged.
// - Data read returns the latch bit for output pins.
// - Data read returns the pin level for input pins.
// - Latch writes always update it; input reads still show the pin.
// - Pullup enable 1 connects pullup on an input pin whose keypad enable is 0.
// - Pullup is forced off while the pin is an output.
// - Keypad enable bit makes its port A pin an interrupt input; the code does not force input, so direction 1 still drives the pin.
// - Keypad pins get pullup or pulldown from their polarity bit.
// - Analog select overrides port logic and routes pin as analog.
// - Pins not selected as analog stay ordinary digital I/O.
// - Port B has eight latch bits, direction from port B direction bits.
// - Reset leaves the port B latch unchanged.
// - Reset clears port B direction; direction 1 drives the pin.
module gpab_port
	import gpab_pkg::*;
#(
	parameter int W = GPAB_PORT_W
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [W-1:0] porta_in,
	output logic [W-1:0] porta_out,
	output logic [W-1:0] porta_oe_n,
	output logic [W-1:0] porta_pull_up,
	output logic [W-1:0] porta_pull_down,
	output logic [W-1:0] porta_analog,
	output logic [W-1:0] keypad_inputs,
	output logic [W-1:0] keypad_active,
	input wire logic [W-1:0] portb_in,
	output logic [W-1:0] portb_out,
	output logic [W-1:0] portb_oe_n
);
	gpab_apb_req_t req;
	logic wr_cyc;
	logic rd_cyc;
	logic hit;
	logic [W-1:0] porta_latch;
	logic [W-1:0] portb_latch;
	logic [W-1:0] porta_dir_reg;
	logic [W-1:0] portb_dir_reg;
	logic [W-1:0] porta_pull_en_reg;
	logic [W-1:0] keypad_irq_enables_reg;
	logic [W-1:0] keypad_polarity_select_reg;
	logic [W-1:0] analog_sel_reg;
	logic [W-1:0] porta_pin_sync;
	logic [W-1:0] portb_pin_sync;
	logic [31:0] prdata_next;
	gpab_pad_ctl_t pad_a;

	// Gather the bus into one request
	assign req = '{sel: psel, enable: penable, write: pwrite,
		addr: paddr, wdata: pwdata};

	// Zero-wait slave: each access phase completes at once
	assign pready = 1'b1;
	assign wr_cyc = req.sel && req.enable && req.write;
	assign rd_cyc = req.sel && !req.enable && !req.write;

	function automatic logic is_reg(input logic [7:0] a,
		input logic [7:0] ofs);
		is_reg = (a == ofs);
	endfunction

	// Known-address test, used only by the error path
	function automatic logic mapped(input logic [7:0] a);
		mapped = is_reg(a, GPAB_OFS_PORTA_LATCH)
			|| is_reg(a, GPAB_OFS_PORTB_LATCH)
			|| is_reg(a, GPAB_OFS_PORTA_DIR)
			|| is_reg(a, GPAB_OFS_PORTB_DIR)
			|| is_reg(a, GPAB_OFS_PORTA_PULL)
			|| is_reg(a, GPAB_OFS_KEYPAD_EN)
			|| is_reg(a, GPAB_OFS_KEYPAD_POL)
			|| is_reg(a, GPAB_OFS_ANALOG_SEL)
			|| is_reg(a, GPAB_OFS_PORTA_PIN);
	endfunction

	// Read data mux: latch where driven, pin where input
	function automatic logic [W-1:0] data_view(input logic [W-1:0] dir,
		input logic [W-1:0] latch, input logic [W-1:0] pin);
		data_view = (dir & latch) | (~dir & pin);
	endfunction

	assign hit = mapped(req.addr);
	assign pslverr = req.sel && req.enable && !hit;

	// Pin levels are asynchronous, so synchronise before any read
	gpab_sync #(.W(W)) u_sync_a (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.async_in(porta_in),
		.sync_out(porta_pin_sync)
	);

	gpab_sync #(.W(W)) u_sync_b (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.async_in(portb_in),
		.sync_out(portb_pin_sync)
	);

	// Latches take every write regardless of direction
	gpab_latch #(.W(W)) u_latch_a (
		.clk_sys(clk_sys),
		.wr_en(wr_cyc && is_reg(req.addr, GPAB_OFS_PORTA_LATCH)),
		.wr_data(req.wdata[W-1:0]),
		.q(porta_latch)
	);

	gpab_latch #(.W(W)) u_latch_b (
		.clk_sys(clk_sys),
		.wr_en(wr_cyc && is_reg(req.addr, GPAB_OFS_PORTB_LATCH)),
		.wr_data(req.wdata[W-1:0]),
		.q(portb_latch)
	);

	// Port A direction, cleared to all inputs by reset
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			porta_dir_reg <= GPAB_DIR_RST;
		else if (wr_cyc && is_reg(req.addr, GPAB_OFS_PORTA_DIR))
			porta_dir_reg <= req.wdata[W-1:0];
	end

	// Port B direction, cleared to all inputs by reset
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			portb_dir_reg <= GPAB_DIR_RST;
		else if (wr_cyc && is_reg(req.addr, GPAB_OFS_PORTB_DIR))
			portb_dir_reg <= req.wdata[W-1:0];
	end

	// Port A pullup enables
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			porta_pull_en_reg <= GPAB_PULL_RST;
		else if (wr_cyc && is_reg(req.addr, GPAB_OFS_PORTA_PULL))
			porta_pull_en_reg <= req.wdata[W-1:0];
	end

	// Keypad enables and polarity
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			keypad_irq_enables_reg <= GPAB_KEY_RST;
			keypad_polarity_select_reg <= GPAB_KEY_RST;
		end
		else
		begin
			if (wr_cyc && is_reg(req.addr, GPAB_OFS_KEYPAD_EN))
				keypad_irq_enables_reg <= req.wdata[W-1:0];
			if (wr_cyc && is_reg(req.addr, GPAB_OFS_KEYPAD_POL))
				keypad_polarity_select_reg <= req.wdata[W-1:0];
		end
	end

	// Converter channel select mirror for port A pins
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			analog_sel_reg <= GPAB_ANA_RST;
		else if (wr_cyc && is_reg(req.addr, GPAB_OFS_ANALOG_SEL))
			analog_sel_reg <= req.wdata[W-1:0];
	end

	// Pad controls for port A; analog wins over every digital setting
	always_comb
	begin
		// Driver on only for digital output pins
		pad_a.drive_n = ~(porta_dir_reg & ~analog_sel_reg);
		pad_a.data = porta_latch;
		// Keypad pins pick pull direction from polarity
		pad_a.pull_up = ~analog_sel_reg & ~porta_dir_reg
			& ((keypad_irq_enables_reg & ~keypad_polarity_select_reg)
			| (~keypad_irq_enables_reg & porta_pull_en_reg));
		pad_a.pull_down = ~analog_sel_reg & ~porta_dir_reg
			& keypad_irq_enables_reg & keypad_polarity_select_reg;
		pad_a.analog = analog_sel_reg;
	end

	assign porta_out = pad_a.data;
	assign porta_oe_n = pad_a.drive_n;
	assign porta_pull_up = pad_a.pull_up;
	assign porta_pull_down = pad_a.pull_down;
	assign porta_analog = pad_a.analog;

	// Keypad view: digital only on enabled, non-analog pins
	assign keypad_active = keypad_irq_enables_reg & ~analog_sel_reg;
	assign keypad_inputs = porta_pin_sync & keypad_active;

	assign portb_out = portb_latch;
	assign portb_oe_n = ~portb_dir_reg;

	// Read mux, sampled at setup so data comes from flip-flops
	always_comb
	begin
		prdata_next = '0;
		unique case (1'b1)
			is_reg(req.addr, GPAB_OFS_PORTA_LATCH):
				prdata_next[W-1:0] = data_view(porta_dir_reg, porta_latch,
					porta_pin_sync);
			is_reg(req.addr, GPAB_OFS_PORTB_LATCH):
				prdata_next[W-1:0] = data_view(portb_dir_reg, portb_latch,
					portb_pin_sync);
			is_reg(req.addr, GPAB_OFS_PORTA_DIR):
				prdata_next[W-1:0] = porta_dir_reg;
			is_reg(req.addr, GPAB_OFS_PORTB_DIR):
				prdata_next[W-1:0] = portb_dir_reg;
			is_reg(req.addr, GPAB_OFS_PORTA_PULL):
				prdata_next[W-1:0] = porta_pull_en_reg;
			is_reg(req.addr, GPAB_OFS_KEYPAD_EN):
				prdata_next[W-1:0] = keypad_irq_enables_reg;
			is_reg(req.addr, GPAB_OFS_KEYPAD_POL):
				prdata_next[W-1:0] = keypad_polarity_select_reg;
			is_reg(req.addr, GPAB_OFS_ANALOG_SEL):
				prdata_next[W-1:0] = analog_sel_reg;
			is_reg(req.addr, GPAB_OFS_PORTA_PIN):
				prdata_next[W-1:0] = porta_pin_sync;
			default:
				prdata_next = '0;
		endcase
	end

	// Capture read data in the setup cycle
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			prdata <= '0;
		else if (rd_cyc)
			prdata <= prdata_next;
	end
endmodule

// *** tb/gpab_port_assertions.sv ***
`timescale 1ns/1ps
// Pad and register relations seen at the port block's pins
module gpab_port_assertions
	import gpab_pkg::*;
#(
	parameter int W = 8
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [W-1:0] porta_out,
	input wire logic [W-1:0] porta_oe_n,
	input wire logic [W-1:0] porta_pull_up,
	input wire logic [W-1:0] porta_pull_down,
	input wire logic [W-1:0] porta_analog,
	input wire logic [W-1:0] keypad_active,
	input wire logic [W-1:0] keypad_inputs,
	input wire logic [W-1:0] portb_out,
	input wire logic [W-1:0] portb_oe_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	// A completed write; direction and analog select writes are the only sources of drive change
	wire logic wr = psel && penable && pwrite;
	AST_ANALOG_OFF: assert property
		((porta_analog & (~porta_oe_n | porta_pull_up)) == '0)
		else $error("analog pin driven");
	AST_OUT_NO_PULL: assert property
		((~porta_oe_n & porta_pull_up) == '0)
		else $error("pullup on output");
	AST_PD_KEY: assert property
		((porta_pull_down & ~keypad_active) == '0)
		else $error("pulldown off keypad");
	AST_KEY_ANA: assert property
		((keypad_active & porta_analog) == '0)
		else $error("keypad on analog pin");
	AST_KEY_MASK: assert property
		((keypad_inputs & ~keypad_active) == '0)
		else $error("keypad input on idle pin");
	AST_DIR_WR: assert property
		(wr && paddr == GPAB_OFS_PORTA_DIR |=>
		porta_oe_n == ~($past(pwdata[W-1:0]) & ~porta_analog))
		else $error("direction write lost");
	AST_LATCH_WR: assert property
		(wr && paddr == GPAB_OFS_PORTA_LATCH |=>
		porta_out == $past(pwdata[W-1:0]))
		else $error("latch write");
	AST_B_LATCH: assert property
		(wr && paddr == GPAB_OFS_PORTB_LATCH |=>
		portb_out == $past(pwdata[W-1:0]))
		else $error("b latch write");
	AST_B_DIR: assert property
		(wr && paddr == GPAB_OFS_PORTB_DIR |=>
		portb_oe_n == ~$past(pwdata[W-1:0]))
		else $error("b dir");
	AST_RST: assert property
		($rose(reset_n) |-> porta_oe_n == '1 && portb_oe_n == '1)
		else $error("pins driven after reset");
	AST_HOLD: assert property
		(!(wr && (paddr == GPAB_OFS_PORTA_DIR ||
		paddr == GPAB_OFS_ANALOG_SEL)) |=> $stable(porta_oe_n))
		else $error("drive changed unasked");
endmodule
bind gpab_port gpab_port_assertions #(.W(W)) u_chk (.clk_sys(clk_sys),
	.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .porta_out(porta_out),
	.porta_oe_n(porta_oe_n), .porta_pull_up(porta_pull_up),
	.porta_pull_down(porta_pull_down), .porta_analog(porta_analog),
	.keypad_active(keypad_active), .keypad_inputs(keypad_inputs),
	.portb_out(portb_out), .portb_oe_n(portb_oe_n));

// *** tb/gpab_pad_model.sv ***
`timescale 1ns/1ps
// Board side of eight pins: our driver wins, then a pull, else ext
module gpab_pad_model
	import gpab_pkg::*;
(
	input wire logic [7:0] drv,
	input wire logic [7:0] oe_n,
	input wire logic [7:0] pu,
	input wire logic [7:0] pd,
	input wire logic [7:0] ext,
	output logic [7:0] pin
);
	// Pull-up and pull-down never both on, so the order here is free
	assign pin = (~oe_n & drv) | (oe_n & (pu | (~pd & ext)));
endmodule

// *** tb/tb_gpab_port.sv ***
`timescale 1ns/1ps
// Bus-driven bench; reads are noted and checked by a monitor
module tb_gpab_port;
	import gpab_pkg::*;
	logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, a_in, a_out, a_oe, a_pu, a_pd, a_an, kin, kact;
	logic [7:0] b_in, b_out, b_oe, ext_a, ext_b, la, da, pe, lb, db, ke, kp;
	logic [7:0] an;
	logic [31:0] pwdata, prdata;
	logic [32:0] exp_q[$];
	logic [7:0] kexp_q[$];
	int fails, samples_checked;
	gpab_port DUT (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .porta_in(a_in),
		.porta_out(a_out), .porta_oe_n(a_oe), .porta_pull_up(a_pu),
		.porta_pull_down(a_pd), .porta_analog(a_an), .keypad_inputs(kin),
		.keypad_active(kact), .portb_in(b_in), .portb_out(b_out),
		.portb_oe_n(b_oe));
	gpab_pad_model u_pa (.drv(a_out), .oe_n(a_oe), .pu(a_pu), .pd(a_pd),
		.ext(ext_a), .pin(a_in));
	gpab_pad_model u_pb (.drv(b_out), .oe_n(b_oe), .pu(8'h00), .pd(8'h00),
		.ext(ext_b), .pin(b_in));
	// Free-running system clock
	initial
	begin
		clk_sys = 0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [32:0] seen, input logic [32:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			fails++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic results();
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One transfer plus an idle edge, so no strobe is set twice at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		psel <= 0;
		penable <= 0;
		@(posedge clk_sys);
		if (n >= 50)
		begin
			fails++;
			results();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] w);
		exp_q.push_back(w);
		apb(0, a, 8'h00);
	endtask
	// Input pins read the pin: keypad pull, else pullup or outside level
	function automatic logic [7:0] pin_a();
		return (la & da) | (~da & ((ke & ~kp) | (~ke & (pe | ext_a))));
	endfunction
	// Read data and error are taken at the access edge, oldest note first
	always @(posedge clk_sys)
		if (psel && penable && !pwrite && pready === 1'b1)
		begin
			chk({pslverr, prdata}, exp_q.pop_front());
			// Keypad view is compared while a raw pin read completes
			if (paddr == GPAB_OFS_PORTA_PIN)
				chk({25'h0, kin}, {25'h0, kexp_q.pop_front()});
		end
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{reset_n, ext_a, ext_b, fails, samples_checked} = '0;
		void'($urandom(97549));
		repeat (6) @(posedge clk_sys);
		reset_n <= 1;
		rd(GPAB_OFS_PORTA_DIR, 33'h0);
		rd(8'h24, {1'b1, 32'h0});
		repeat (8)
		begin
			{la, da, pe, lb, db, ke, kp, an} = {$urandom, $urandom};
			ext_a <= 8'($urandom);
			ext_b <= 8'($urandom);
			apb(1, GPAB_OFS_ANALOG_SEL, an);
			rd(GPAB_OFS_ANALOG_SEL, {25'h0, an});
			apb(1, GPAB_OFS_ANALOG_SEL, 8'h00);
			apb(1, GPAB_OFS_PORTA_LATCH, la);
			apb(1, GPAB_OFS_PORTB_LATCH, lb);
			apb(1, GPAB_OFS_PORTA_DIR, da);
			apb(1, GPAB_OFS_PORTB_DIR, db);
			apb(1, GPAB_OFS_PORTA_PULL, pe);
			apb(1, GPAB_OFS_KEYPAD_EN, ke);
			apb(1, GPAB_OFS_KEYPAD_POL, kp);
			repeat (3) @(posedge clk_sys);
			rd(GPAB_OFS_PORTA_LATCH, {25'h0, pin_a()});
			kexp_q.push_back(pin_a() & ke);
			rd(GPAB_OFS_PORTA_PIN, {25'h0, pin_a()});
			rd(GPAB_OFS_PORTA_DIR, {25'h0, da});
			rd(GPAB_OFS_PORTA_PULL, {25'h0, pe});
			rd(GPAB_OFS_PORTB_LATCH, {25'h0, (lb & db) | (~db & ext_b)});
			rd(GPAB_OFS_PORTB_DIR, {25'h0, db});
			rd(GPAB_OFS_KEYPAD_EN, {25'h0, ke});
			rd(GPAB_OFS_KEYPAD_POL, {25'h0, kp});
		end
		reset_n <= 0;
		@(posedge clk_sys);
		reset_n <= 1;
		@(posedge clk_sys);
		rd(GPAB_OFS_PORTA_DIR, 33'h0);
		apb(1, GPAB_OFS_PORTA_DIR, 8'hff);
		rd(GPAB_OFS_PORTA_LATCH, {25'h0, la});
		apb(1, GPAB_OFS_PORTB_DIR, 8'hff);
		rd(GPAB_OFS_PORTB_LATCH, {25'h0, lb});
		results();
	end
endmodule
